/* src/pin_function_mux.sv */
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module pin_function_mux #(
  parameter int unsigned ADDR_W = 12
) (
  // clock, reset, enable
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                ce,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic                     pready,
  output logic                     pslverr,
  output logic [31:0]              prdata,
  // pin levels
  input  wire pin_mux_pkg::pins_s  pins,
  // pin function selection
  output logic [63:0]              pin_code,
  output logic [31:0]              pin_gpio,
  output logic                     config_fault,
  // routed peripheral inputs
  output pin_mux_pkg::route_s      route
);
  import pin_mux_pkg::*;

  // elaboration check: decoder needs bits above the word index to test for zero
  if (ADDR_W < 7) begin : g_bad_addr
    $error("ADDR_W must be at least 7");
  end

  logic [7:0]  regs_reg [NUM_REGS];
  logic [31:0] prdata_reg;
  logic [31:0] gpio_reg;
  logic [31:0] gpio_next;
  route_s      route_reg;
  route_s      route_next;
  logic        fault_reg;
  logic        fault_next;

  // address decode: aligned, in range, upper bits clear
  wire  [3:0]  reg_idx   = paddr[5:2];
  wire         addr_ok   = (paddr[1:0] == 2'b00) && (reg_idx < 4'(NUM_REGS))
                           && (paddr[ADDR_W-1:6] == '0);
  wire         setup_ph  = psel && !penable;
  wire         access_ph = psel && penable;
  wire         wr_take   = access_ph && pwrite && addr_ok && ce && pstrb[0];

  // wait states come only from a frozen clock enable
  assign pready  = ce;
  assign pslverr = access_ph && !addr_ok;
  assign prdata  = prdata_reg;

  // per-register mask of implemented bits
  function automatic logic [7:0] impl_mask(input logic [3:0] idx);
    logic [7:0] m;
    m = MASK_FULL;
    if (idx == IDX_PD_HIGH) m = MASK_PDHIGH;
    if (idx == IDX_TCLK || idx == IDX_TCAP || idx == IDX_SERIRQ) m = MASK_IFS7;
    if (idx == IDX_UARTRX) m = MASK_UARTRX;
    return m;
  endfunction : impl_mask

  wire  [7:0]  rd_byte = addr_ok ? (regs_reg[reg_idx] & impl_mask(reg_idx)) : 8'h00;

  // register file, byte lane 0 only
  // all zero at reset
  genvar r;
  for (r = 0; r < NUM_REGS; r++) begin : g_regs
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        regs_reg[r] <= REG_RESET;
      end else if (wr_take && reg_idx == 4'(r)) begin
        regs_reg[r] <= pwdata[7:0] & impl_mask(4'(r));
      end
    end
  end

  // read data sampled in setup so it is stable through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (ce && setup_ph && !pwrite) begin
      prdata_reg <= {24'h00_0000, rd_byte};
    end
  end

  // per pin GPIO decode from its two-bit code
  // per-pin tables
  genvar p;
  for (p = 0; p < 32; p++) begin : g_pin
    wire [1:0] code = regs_reg[p / 4][2 * (p % 4) +: 2];
    assign gpio_next[p] = GPIO_CODES[4 * p + int'(code)];
    assign pin_code[2 * p +: 2] = code;
  end

  // reserved codes: port E lines 5-7 at 10, and reserved periodic timer 1-3 clock routes
  // reserved code flagged
  wire [7:0] pe_hi = regs_reg[IDX_PE_HIGH];
  wire       pe_res = (pe_hi[7:6] == 2'b10) || (pe_hi[5:4] == 2'b10)
                      || (pe_hi[3:2] == 2'b10);
  wire [7:0] tclk = regs_reg[IDX_TCLK];
  wire       rt_res = !tclk[B_PT3] || !tclk[B_PT2] || tclk[B_PT1];
  assign fault_next = pe_res || rt_res;

  wire [7:0] tcap = regs_reg[IDX_TCAP];
  wire [7:0] sirq = regs_reg[IDX_SERIRQ];
  wire [7:0] ptup = regs_reg[IDX_PTUPPER];
  wire [7:0] urx  = regs_reg[IDX_UARTRX];

  // timer clock routing; an invalid choice feeds a constant low
  // timer clock sources
  assign route_next.st_clk[0]    = tclk[B_ST0] ? 1'b0 : pins.pc[7];
  assign route_next.st_clk[1]    = tclk[B_ST1] ? pins.pb[7] : pins.pd[1];
  assign route_next.st_clk[2]    = tclk[B_ST2] ? pins.pb[0] : pins.pf[6];
  assign route_next.pt_clk_lo[0] = tclk[B_PT0] ? pins.pf[4] : pins.pc[3];
  assign route_next.pt_clk_lo[1] = tclk[B_PT1] ? 1'b0 : pins.pc[5];
  assign route_next.pt_clk_lo[2] = tclk[B_PT2] ? pins.pb[2] : 1'b0;
  assign route_next.pt_clk_lo[3] = tclk[B_PT3] ? pins.pb[1] : 1'b0;

  // capture input routing
  // capture sources
  assign route_next.st_cap[0]    = tcap[B_ST0] ? 1'b0 : pins.pc[6];
  assign route_next.st_cap[1]    = tcap[B_ST1] ? pins.pb[6] : pins.pd[0];
  assign route_next.st_cap[2]    = tcap[B_ST2] ? pins.pf[7] : pins.pd[6];
  assign route_next.pt_cap_lo[0] = tcap[B_PT0] ? pins.pf[5] : pins.pc[2];
  assign route_next.pt_cap_lo[1] = tcap[B_PT1] ? 1'b0 : pins.pc[4];
  assign route_next.pt_cap_lo[2] = tcap[B_PT2] ? pins.pb[3] : 1'b0;
  assign route_next.pt_cap_lo[3] = tcap[B_PT3] ? pins.pb[2] : 1'b0;

  // serial interface and interrupt routing
  // serial input sources
  assign route_next.scs_in  = sirq[B_SCS] ? 1'b0 : pins.pa[1];
  assign route_next.sdi_in  = sirq[B_SDI] ? pins.pf[2] : pins.pa[4];
  assign route_next.sck_in  = sirq[B_SCK] ? 1'b0 : pins.pa[5];
  assign route_next.ext_irq[0] = sirq[B_INT0] ? pins.pa[6] : pins.pa[1];
  assign route_next.ext_irq[1] = sirq[B_INT1] ? pins.pa[7] : pins.pa[3];
  assign route_next.ext_irq[2] = sirq[B_INT2] ? pins.pd[0] : pins.pa[4];
  assign route_next.ext_irq[3] = sirq[B_INT3] ? pins.pc[7] : pins.pa[5];

  // upper periodic timer routing; lines 4 and 5 clocks and 7 capture unrouted
  // upper periodic sources
  assign route_next.pt_clk_hi[0] = ptup[B_PK6] ? pins.pc[2] : pins.pf[2];
  assign route_next.pt_clk_hi[1] = ptup[B_PK7] ? pins.pc[4] : 1'b0;
  assign route_next.pt_cap_hi[0] = ptup[B_PC4] ? 1'b0 : pins.pc[3];
  assign route_next.pt_cap_hi[1] = ptup[B_PC5] ? 1'b0 : pins.pc[5];
  assign route_next.pt_cap_hi[2] = ptup[B_PC6] ? 1'b0 : pins.pc[7];

  // uart receive routing
  // uart receive sources
  assign route_next.uart_rx[0] = urx[B_RX0] ? 1'b0 : pins.pa[6];
  assign route_next.uart_rx[1] = urx[B_RX1] ? pins.pf[6] : pins.pd[1];

  // outputs registered; one cycle from pin to peripheral
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      route_reg <= '0;
      gpio_reg  <= 32'hFFFF_FFFF;
      fault_reg <= 1'b0;
    end else if (ce) begin
      route_reg <= route_next;
      gpio_reg  <= gpio_next;
      fault_reg <= fault_next;
    end
  end

  assign route        = route_reg;
  assign pin_gpio     = gpio_reg;
  assign config_fault = fault_reg;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  pd1_func_a: assert property (ce |=> pin_gpio[1] == ($past(regs_reg[0][3:2]) == 2'b00))
    else $error("port D line 1 GPIO decode wrong");
  pd0_func_a: assert property (ce |=> pin_gpio[0] == ($past(regs_reg[0][1:0]) == 2'b00))
    else $error("port D line 0 GPIO decode wrong");
  pd_high_zero_a: assert property (regs_reg[IDX_PD_HIGH][7:6] == 2'b00
    && regs_reg[IDX_UARTRX][7:2] == 6'h00 && regs_reg[IDX_TCLK][7] == 1'b0)
    else $error("unimplemented bits hold ones");
  pd6_func_a: assert property (ce |=> pin_gpio[6] == ($past(regs_reg[1][5:4]) == 2'b00))
    else $error("port D line 6 GPIO decode wrong");
  pe0_func_a: assert property (ce |=> pin_gpio[8] == !$past(regs_reg[2][1]))
    else $error("port E line 0 GPIO decode wrong");
  pe_reserved_a: assert property (ce && regs_reg[3][7:6] == 2'b10 |=> config_fault)
    else $error("reserved port E code not flagged");
  pe4_func_a: assert property (ce |=> pin_gpio[12] == ($past(regs_reg[3][1:0]) != 2'b11))
    else $error("port E line 4 GPIO decode wrong");
  pf2_func_a: assert property (ce |=> pin_gpio[18] == !$past(regs_reg[4][5]))
    else $error("port F line 2 GPIO decode wrong");
  pg_common_a: assert property (ce |=> pin_gpio[27:24] == 4'hF || $past(regs_reg[6]) != 8'h00)
    else $error("port G low pins not GPIO at code 00");
  pg4_func_a: assert property (ce && regs_reg[7][1:0] == 2'b10 |=> !pin_gpio[28])
    else $error("port G line 4 GPIO at code 10");
  st1_clk_a: assert property (ce |=> route.st_clk[1] ==
    ($past(regs_reg[IDX_TCLK][B_ST1]) ? $past(pins.pb[7]) : $past(pins.pd[1])))
    else $error("standard timer 1 clock misrouted");
  pt0_cap_a: assert property (ce |=> route.pt_cap_lo[0] ==
    ($past(regs_reg[IDX_TCAP][B_PT0]) ? $past(pins.pf[5]) : $past(pins.pc[2])))
    else $error("periodic timer 0 capture misrouted");
  sdi_route_a: assert property (ce |=> route.sdi_in ==
    ($past(regs_reg[IDX_SERIRQ][B_SDI]) ? $past(pins.pf[2]) : $past(pins.pa[4])))
    else $error("serial data input misrouted");
  irq2_route_a: assert property (ce && !regs_reg[IDX_SERIRQ][B_INT2]
    |=> route.ext_irq[2] == $past(pins.pa[4]))
    else $error("unselected pin reached interrupt 2");
  pt7_clk_a: assert property (ce && !regs_reg[IDX_PTUPPER][B_PK7] |=> !route.pt_clk_hi[1])
    else $error("timer 7 clock driven from reserved route");
  rx1_route_a: assert property (ce |=> route.uart_rx[1] ==
    ($past(regs_reg[IDX_UARTRX][B_RX1]) ? $past(pins.pf[6]) : $past(pins.pd[1])))
    else $error("uart 1 receive misrouted");
  write_hold_a: assert property (!ce |=> $stable(regs_reg[0]) && $stable(route))
    else $error("state moved while clock enable low");

  pe5_func_a: assert property (ce |=>
    pin_gpio[13] == !$past(regs_reg[IDX_PE_HIGH][3]))
    else $error("port E line 5 GPIO decode wrong");
  pe6_func_a: assert property (ce |=>
    pin_gpio[14] == !$past(regs_reg[IDX_PE_HIGH][5]))
    else $error("port E line 6 GPIO decode wrong");
  pe7_func_a: assert property (ce |=>
    pin_gpio[15] == !$past(regs_reg[IDX_PE_HIGH][7]))
    else $error("port E line 7 GPIO decode wrong");
  pe5_reserved_a: assert property (ce && regs_reg[IDX_PE_HIGH][3:2] == 2'b10
    |=> config_fault)
    else $error("reserved port E line 5 code not flagged");
  pe6_reserved_a: assert property (ce && regs_reg[IDX_PE_HIGH][5:4] == 2'b10
    |=> config_fault)
    else $error("reserved port E line 6 code not flagged");

  pf7_func_a: assert property (ce |=>
    pin_gpio[23] == ($past(regs_reg[IDX_PF_HIGH][7:6]) == 2'b00))
    else $error("port F line 7 GPIO decode wrong");
  pf6_func_a: assert property (ce |=>
    pin_gpio[22] == ($past(regs_reg[IDX_PF_HIGH][5:4]) == 2'b00))
    else $error("port F line 6 GPIO decode wrong");
  pf5_func_a: assert property (ce |=>
    pin_gpio[21] == !$past(regs_reg[IDX_PF_HIGH][3]))
    else $error("port F line 5 GPIO decode wrong");
  pf4_func_a: assert property (ce |=>
    pin_gpio[20] == ($past(regs_reg[IDX_PF_HIGH][1:0]) != 2'b11))
    else $error("port F line 4 GPIO decode wrong");

  // port G, one check per line, lines g and g+4 in each loop step
  for (genvar g = 0; g < 4; g++) begin : g_pg_chk
    pg_low_func_a: assert property (ce |=>
      pin_gpio[24 + g] == ($past(regs_reg[IDX_PG_LOW][2 * g +: 2]) != 2'b11))
      else $error("port G low line GPIO decode wrong");
    pg_high_func_a: assert property (ce |=>
      pin_gpio[28 + g] == !$past(regs_reg[IDX_PG_HIGH][2 * g + 1]))
      else $error("port G high line GPIO decode wrong");
  end

  st0_clk_a: assert property (ce |=> route.st_clk[0] ==
    ($past(tclk[B_ST0]) ? 1'b0 : $past(pins.pc[7])))
    else $error("standard timer 0 clock misrouted");
  st2_clk_a: assert property (ce |=> route.st_clk[2] ==
    ($past(tclk[B_ST2]) ? $past(pins.pb[0]) : $past(pins.pf[6])))
    else $error("standard timer 2 clock misrouted");
  pt0_clk_a: assert property (ce |=> route.pt_clk_lo[0] ==
    ($past(tclk[B_PT0]) ? $past(pins.pf[4]) : $past(pins.pc[3])))
    else $error("periodic timer 0 clock misrouted");
  pt3_clk_a: assert property (ce |=> route.pt_clk_lo[3] ==
    ($past(tclk[B_PT3]) ? $past(pins.pb[1]) : 1'b0))
    else $error("periodic timer 3 clock misrouted");
  pt1_clk_a: assert property (ce && tclk[B_PT1]
    |=> !route.pt_clk_lo[1])
    else $error("timer 1 clock driven from reserved route");

  st0_cap_a: assert property (ce |=> route.st_cap[0] ==
    ($past(tcap[B_ST0]) ? 1'b0 : $past(pins.pc[6])))
    else $error("standard timer 0 capture misrouted");
  st1_cap_a: assert property (ce |=> route.st_cap[1] ==
    ($past(tcap[B_ST1]) ? $past(pins.pb[6]) : $past(pins.pd[0])))
    else $error("standard timer 1 capture misrouted");
  st2_cap_a: assert property (ce |=> route.st_cap[2] ==
    ($past(tcap[B_ST2]) ? $past(pins.pf[7]) : $past(pins.pd[6])))
    else $error("standard timer 2 capture misrouted");
  pt2_cap_a: assert property (ce |=> route.pt_cap_lo[2] ==
    ($past(tcap[B_PT2]) ? $past(pins.pb[3]) : 1'b0))
    else $error("periodic timer 2 capture misrouted");

  scs_route_a: assert property (ce |=> route.scs_in ==
    ($past(sirq[B_SCS]) ? 1'b0 : $past(pins.pa[1])))
    else $error("chip select input misrouted");
  sck_route_a: assert property (ce |=> route.sck_in ==
    ($past(sirq[B_SCK]) ? 1'b0 : $past(pins.pa[5])))
    else $error("serial clock input misrouted");
  irq0_route_a: assert property (ce |=> route.ext_irq[0] ==
    ($past(sirq[B_INT0]) ? $past(pins.pa[6]) : $past(pins.pa[1])))
    else $error("interrupt 0 misrouted");
  irq1_route_a: assert property (ce |=> route.ext_irq[1] ==
    ($past(sirq[B_INT1]) ? $past(pins.pa[7]) : $past(pins.pa[3])))
    else $error("interrupt 1 misrouted");
  irq3_route_a: assert property (ce |=> route.ext_irq[3] ==
    ($past(sirq[B_INT3]) ? $past(pins.pc[7]) : $past(pins.pa[5])))
    else $error("interrupt 3 misrouted");
  irq2_alt_a: assert property (ce && sirq[B_INT2]
    |=> route.ext_irq[2] == $past(pins.pd[0]))
    else $error("unselected pin reached interrupt 2");

  // upper periodic timers and uart receive
  pt6_clk_a: assert property (ce |=> route.pt_clk_hi[0] ==
    ($past(ptup[B_PK6]) ? $past(pins.pc[2]) : $past(pins.pf[2])))
    else $error("periodic timer 6 clock misrouted");
  pt4_cap_a: assert property (ce |=> route.pt_cap_hi[0] ==
    ($past(ptup[B_PC4]) ? 1'b0 : $past(pins.pc[3])))
    else $error("periodic timer 4 capture misrouted");
  pt5_cap_a: assert property (ce |=> route.pt_cap_hi[1] ==
    ($past(ptup[B_PC5]) ? 1'b0 : $past(pins.pc[5])))
    else $error("periodic timer 5 capture misrouted");
  pt6_cap_a: assert property (ce |=> route.pt_cap_hi[2] ==
    ($past(ptup[B_PC6]) ? 1'b0 : $past(pins.pc[7])))
    else $error("periodic timer 6 capture misrouted");
  rx0_route_a: assert property (ce |=> route.uart_rx[0] ==
    ($past(urx[B_RX0]) ? 1'b0 : $past(pins.pa[6])))
    else $error("uart 0 receive misrouted");

  // reserved routes flagged, upper read bits
  route_res_a: assert property (ce && !tclk[B_PT2]
    |=> config_fault)
    else $error("reserved timer clock route not flagged");
  prdata_upper_a: assert property (ce |->
    prdata[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");

  cov_write_c: cover property (wr_take ##1 access_ph && !pwrite);
  cov_badaddr_c: cover property (pslverr && pready);
  cov_rx1_alt_c: cover property (regs_reg[IDX_UARTRX][B_RX1] && route.uart_rx[1]);
  cov_fault_c: cover property ($rose(config_fault));

endmodule : pin_function_mux
`default_nettype wire

/* src/pin_mux_pkg.sv */
package pin_mux_pkg;

  // register byte offsets, one aligned word each
  localparam logic [5:0] OFF_PD_LOW   = 6'h00;
  localparam logic [5:0] OFF_PD_HIGH  = 6'h04;
  localparam logic [5:0] OFF_PE_LOW   = 6'h08;
  localparam logic [5:0] OFF_PE_HIGH  = 6'h0C;
  localparam logic [5:0] OFF_PF_LOW   = 6'h10;
  localparam logic [5:0] OFF_PF_HIGH  = 6'h14;
  localparam logic [5:0] OFF_PG_LOW   = 6'h18;
  localparam logic [5:0] OFF_PG_HIGH  = 6'h1C;
  localparam logic [5:0] OFF_TCLK     = 6'h20;
  localparam logic [5:0] OFF_TCAP     = 6'h24;
  localparam logic [5:0] OFF_SERIRQ   = 6'h28;
  localparam logic [5:0] OFF_PTUPPER  = 6'h2C;
  localparam logic [5:0] OFF_UARTRX   = 6'h30;

  localparam int unsigned NUM_REGS = 13;
  localparam int unsigned NUM_SEL  = 8;

  // register indices
  localparam logic [3:0] IDX_PD_LOW  = 4'h0;
  localparam logic [3:0] IDX_PD_HIGH = 4'h1;
  localparam logic [3:0] IDX_PE_HIGH = 4'h3;
  localparam logic [3:0] IDX_PF_LOW  = 4'h4;
  localparam logic [3:0] IDX_PF_HIGH = 4'h5;
  localparam logic [3:0] IDX_PG_LOW  = 4'h6;
  localparam logic [3:0] IDX_PG_HIGH = 4'h7;
  localparam logic [3:0] IDX_TCLK    = 4'h8;
  localparam logic [3:0] IDX_TCAP    = 4'h9;
  localparam logic [3:0] IDX_SERIRQ  = 4'hA;
  localparam logic [3:0] IDX_PTUPPER = 4'hB;
  localparam logic [3:0] IDX_UARTRX  = 4'hC;

  localparam logic [7:0] REG_RESET = 8'h00;

  // implemented-bit masks per register index
  localparam logic [7:0] MASK_FULL   = 8'hFF;
  localparam logic [7:0] MASK_PDHIGH = 8'h3F;
  localparam logic [7:0] MASK_IFS7   = 8'h7F;
  localparam logic [7:0] MASK_UARTRX = 8'h03;

  // one nibble per pin (D0 lowest, G7 highest); bit c set when code c is GPIO
  localparam logic [127:0] GPIO_CODES =
    128'h33337777_11371311_33371113_11111111;

  // routing bit positions
  localparam int unsigned B_ST0  = 0;
  localparam int unsigned B_ST1  = 1;
  localparam int unsigned B_ST2  = 2;
  localparam int unsigned B_PT0  = 3;
  localparam int unsigned B_PT1  = 4;
  localparam int unsigned B_PT2  = 5;
  localparam int unsigned B_PT3  = 6;
  localparam int unsigned B_INT0 = 0;
  localparam int unsigned B_INT1 = 1;
  localparam int unsigned B_INT2 = 2;
  localparam int unsigned B_INT3 = 3;
  localparam int unsigned B_SCK  = 4;
  localparam int unsigned B_SDI  = 5;
  localparam int unsigned B_SCS  = 6;
  localparam int unsigned B_PC4  = 0;
  localparam int unsigned B_PC5  = 1;
  localparam int unsigned B_PC6  = 2;
  localparam int unsigned B_PK6  = 6;
  localparam int unsigned B_PK7  = 7;
  localparam int unsigned B_RX0  = 0;
  localparam int unsigned B_RX1  = 1;

  // pin levels entering the block, one byte per port
  typedef struct packed {
    logic [7:0] pa;
    logic [7:0] pb;
    logic [7:0] pc;
    logic [7:0] pd;
    logic [7:0] pf;
  } pins_s;

  // routed peripheral inputs
  typedef struct packed {
    logic [2:0] st_clk;
    logic [3:0] pt_clk_lo;
    logic [1:0] pt_clk_hi;
    logic [2:0] st_cap;
    logic [3:0] pt_cap_lo;
    logic [2:0] pt_cap_hi;
    logic       scs_in;
    logic       sdi_in;
    logic       sck_in;
    logic [3:0] ext_irq;
    logic [1:0] uart_rx;
  } route_s;

endpackage : pin_mux_pkg

/* verif/test_pin_function_mux.sv */
`timescale 1ns/100ps
`default_nettype none
module test_pin_function_mux;
  import pin_mux_pkg::*;
  // bench drive and observe
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        ce = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0]  pstrb = 4'hF;
  logic        pready;
  logic        pslverr;
  logic [31:0] prdata;
  pins_s       pins = '0;
  logic [63:0] pin_code;
  logic [31:0] pin_gpio;
  logic        config_fault;
  route_s      route;
  logic        err_seen;
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          cycles = 0;
  // register map, readable-bit masks and gpio codes per pin (bit c of nibble)
  localparam logic [5:0] OFFS [13] = '{OFF_PD_LOW, OFF_PD_HIGH, OFF_PE_LOW, OFF_PE_HIGH,
    OFF_PF_LOW, OFF_PF_HIGH, OFF_PG_LOW, OFF_PG_HIGH, OFF_TCLK, OFF_TCAP, OFF_SERIRQ,
    OFF_PTUPPER, OFF_UARTRX};
  localparam logic [7:0] MASKS [13] = '{8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'h7F, 8'h7F, 8'h7F, 8'hFF, 8'h03};
  localparam logic [127:0] GPIO_TBL = 128'h33337777_11371311_33371113_11111111;
  // two routing settings, only legal choices; timer 2/3 clocks on their pins
  localparam logic [5:0] RTOFF [5] = '{OFF_TCLK, OFF_TCAP, OFF_SERIRQ, OFF_PTUPPER, OFF_UARTRX};
  localparam logic [7:0] RS [2][5] = '{'{8'h60, 8'h60, 8'h00, 8'h80, 8'h00},
    '{8'h6E, 8'h6E, 8'h2F, 8'hC0, 8'h02}};

  pin_function_mux #(.ADDR_W(12)) dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .pslverr(pslverr), .prdata(prdata), .pins(pins), .pin_code(pin_code),
    .pin_gpio(pin_gpio), .config_fault(config_fault), .route(route));

  always #4 pclk = ~pclk;

  // hang guard, well above the few hundred cycles needed
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      results();
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; waits for pready, takes data and error at that edge
  task automatic apb(input logic wr, input logic [5:0] a, input logic [7:0] d,
                     input logic [3:0] s, output logic [31:0] rd);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {6'h00, a};
    pwdata  <= {24'h000000, d};
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err_seen = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [31:0] x;
    apb(1'b1, a, d, 4'hF, x);
  endtask : wr

  task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
    logic [31:0] x;
    apb(1'b0, a, 8'h00, 4'hF, x);
    chk(64'(x), 64'(e));
  endtask : rd_chk

  // expected routed inputs for pin levels p and routing bytes
  function automatic route_s exp_route(input pins_s p, input logic [7:0] t, input logic [7:0] c,
                                       input logic [7:0] s, input logic [7:0] u,
                                       input logic [7:0] x);
    route_s r;
    r.st_clk    = {t[2] ? p.pb[0] : p.pf[6], t[1] ? p.pb[7] : p.pd[1], p.pc[7]};
    r.pt_clk_lo = {p.pb[1], p.pb[2], p.pc[5], t[3] ? p.pf[4] : p.pc[3]};
    r.pt_clk_hi = {p.pc[4], u[6] ? p.pc[2] : p.pf[2]};
    r.st_cap    = {c[2] ? p.pf[7] : p.pd[6], c[1] ? p.pb[6] : p.pd[0], p.pc[6]};
    r.pt_cap_lo = {p.pb[2], p.pb[3], p.pc[4], c[3] ? p.pf[5] : p.pc[2]};
    r.pt_cap_hi = {p.pc[7], p.pc[5], p.pc[3]};
    r.scs_in    = p.pa[1];
    r.sdi_in    = s[5] ? p.pf[2] : p.pa[4];
    r.sck_in    = p.pa[5];
    r.ext_irq   = {s[3] ? p.pc[7] : p.pa[5], s[2] ? p.pd[0] : p.pa[4],
                   s[1] ? p.pa[7] : p.pa[3], s[0] ? p.pa[6] : p.pa[1]};
    r.uart_rx   = {x[1] ? p.pf[6] : p.pd[1], p.pa[6]};
    return r;
  endfunction : exp_route

  // reset values, masks, strobe-less write, unmapped and misaligned access
  task automatic t_regs();
    logic [31:0] x;
    @(negedge pclk);
    chk(64'(pin_gpio), 64'(32'hFFFFFFFF));
    chk(64'(config_fault), 64'(1'b1));
    for (int i = 0; i < 13; i++) begin
      rd_chk(OFFS[i], 8'h00);
      wr(OFFS[i], 8'hFF);
      rd_chk(OFFS[i], MASKS[i]);
      apb(1'b1, OFFS[i], 8'h00, 4'h0, x);
      rd_chk(OFFS[i], MASKS[i]);
      wr(OFFS[i], 8'h00);
    end
    apb(1'b0, 6'h34, 8'h00, 4'hF, x);
    chk(64'({err_seen, x}), 64'({1'b1, 32'h00000000}));
    apb(1'b1, 6'h02, 8'hFF, 4'hF, x);
    chk(64'(err_seen), 64'(1'b1));
    rd_chk(OFF_PD_LOW, 8'h00);
  endtask : t_regs

  // every code on every selector field at once
  task automatic t_codes();
    logic [63:0] ec;
    logic [31:0] eg;
    logic [7:0]  b;
    wr(OFF_TCLK, 8'h60);
    for (int c = 0; c < 4; c++) begin
      b = {4{2'(c)}};
      for (int i = 0; i < 8; i++) begin
        wr(OFFS[i], b);
        ec[8*i+:8] = b & MASKS[i];
      end
      for (int p = 0; p < 32; p++) eg[p] = GPIO_TBL[4*p+int'(ec[2*p+:2])];
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      chk(pin_code, ec);
      chk(64'(pin_gpio), 64'(eg));
      chk(64'(config_fault), 64'(c == 2));
    end
    for (int i = 0; i < 8; i++) wr(OFFS[i], 8'h00);
  endtask : t_codes

  // port-wide patterns and inverses make every candidate pair disagree
  task automatic t_routes();
    pins_s  pt;
    route_s held;
    for (int s = 0; s < 2; s++) begin
      for (int r = 0; r < 5; r++) wr(RTOFF[r], RS[s][r]);
      for (int j = 0; j < 12; j++) begin
        pt = (j < 10) ? (40'hFF << (8 * (j / 2))) : {8'h0F, 32'h00000000};
        if (j % 2 == 1) pt = ~pt;
        @(posedge pclk);
        pins <= pt;
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        chk(64'(route), 64'(exp_route(pt, RS[s][0], RS[s][1], RS[s][2], RS[s][3],
            RS[s][4])));
      end
    end
    // clock enable low freezes the routed inputs and the bus
    @(negedge pclk);
    held = route;
    @(posedge pclk);
    ce   <= 1'b0;
    pins <= ~pt;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    chk(64'({pready, route}), 64'({1'b0, held}));
    @(posedge pclk);
    ce <= 1'b1;
  endtask : t_routes

  task automatic results();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    t_regs();
    t_codes();
    t_routes();
    results();
  end
endmodule : test_pin_function_mux
`default_nettype wire
